// ===== lkd_pkg.sv
/*
 * lkd_pkg: constants, configuration layout and states for the digital
 * lock detector.
 * assumes a single 125 MHz mclk; time figures are in picoseconds.
 */
package lkd_pkg;

    // register offsets and reset values
    localparam logic [7:0] REG_PLL_PFD_PULSE_CONFIG = 8'h17;
    localparam logic [7:0] REG_LOCK_DETECT_CONFIG   = 8'h18;
    localparam logic [7:0] RST_PLL_PFD_PULSE_CONFIG = 8'h00;
    localparam logic [7:0] RST_LOCK_DETECT_CONFIG   = 8'h00;

    // field positions inside lock_detect_config
    localparam int FLD_CNT_LEN_LSB = 5;
    localparam int FLD_RANGE_LO    = 4;
    localparam int FLD_DETECT_OFF  = 3;

    // clock and time figures
    localparam int CLK_PERIOD_PS = 8000;
    localparam int WIN_HI_PS     = 3500;
    localparam int WIN_LO_PS     = 16000;
    localparam int LOSS_HI_PS    = 24000;
    localparam int LOSS_LO_PS    = 40000;

    // longest times: round down, never below one cycle
    localparam int WIN_HI_CYC  = (WIN_HI_PS / CLK_PERIOD_PS < 1) ? 1 :
                                 WIN_HI_PS / CLK_PERIOD_PS;
    localparam int WIN_LO_CYC  = (WIN_LO_PS / CLK_PERIOD_PS < 1) ? 1 :
                                 WIN_LO_PS / CLK_PERIOD_PS;
    localparam int LOSS_HI_CYC = (LOSS_HI_PS / CLK_PERIOD_PS < 1) ? 1 :
                                 LOSS_HI_PS / CLK_PERIOD_PS;
    localparam int LOSS_LO_CYC = (LOSS_LO_PS / CLK_PERIOD_PS < 1) ? 1 :
                                 LOSS_LO_PS / CLK_PERIOD_PS;

    // in-window detector cycles needed per counter-length code
    localparam logic [7:0] LOCK_CNT_00 = 8'h05;
    localparam logic [7:0] LOCK_CNT_01 = 8'h10;
    localparam logic [7:0] LOCK_CNT_10 = 8'h40;
    localparam logic [7:0] LOCK_CNT_11 = 8'hFF;

    typedef struct packed {
        logic       cmosOffset;
        logic [1:0] cntLen;
        logic       rangeLo;
        logic       detectOff;
        logic [1:0] calDiv;
        logic       spare;
    } lkd_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_FB,
        ST_WAIT_REF
    } lkd_state_e;

endpackage

// ===== lkd_digital_lock_detect.sv
/*
 * lkd_digital_lock_detect: digital lock detector with its two config
 * registers on a plain register port.
 * assumes the detector edge inputs are asynchronous pins; edge separation
 * is resolved in whole mclk cycles (8 ns), so windows are coarse.
 */
`timescale 1ns/1ps

module lkd_digital_lock_detect (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       phaseFreqDetectorRef,
    input  wire logic       phaseFreqDetectorFb,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    output logic            lockFlagDigital
);

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]         pllPfdPulseConfig;
    logic [7:0]         lockDetectConfig;
    lkd_pkg::lkd_cfg_s  cfg;

    assign cfg = lkd_pkg::lkd_cfg_s'(lockDetectConfig);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pllPfdPulseConfig <= lkd_pkg::RST_PLL_PFD_PULSE_CONFIG;
            lockDetectConfig  <= lkd_pkg::RST_LOCK_DETECT_CONFIG;
        end else if (regWrEn) begin
            if (regAddr == lkd_pkg::REG_PLL_PFD_PULSE_CONFIG) begin
                pllPfdPulseConfig <= regWrData;
            end
            if (regAddr == lkd_pkg::REG_LOCK_DETECT_CONFIG) begin
                lockDetectConfig <= regWrData;
            end
        end
    end

    // read data one cycle after the address; unmapped reads zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regAddr == lkd_pkg::REG_PLL_PFD_PULSE_CONFIG) begin
            regRdData <= pllPfdPulseConfig;
        end else if (regAddr == lkd_pkg::REG_LOCK_DETECT_CONFIG) begin
            regRdData <= lockDetectConfig;
        end else begin
            regRdData <= 8'h00;
        end
    end

    function automatic logic [7:0] lock_target(input logic [1:0] code);
        unique case (code)
            2'b00: lock_target = lkd_pkg::LOCK_CNT_00;
            2'b01: lock_target = lkd_pkg::LOCK_CNT_01;
            2'b10: lock_target = lkd_pkg::LOCK_CNT_10;
            2'b11: lock_target = lkd_pkg::LOCK_CNT_11;
        endcase
    endfunction

    logic [7:0] winCyc;
    logic [7:0] lossCyc;
    logic [7:0] target;

    assign winCyc  = cfg.rangeLo ? 8'(lkd_pkg::WIN_LO_CYC)
                                 : 8'(lkd_pkg::WIN_HI_CYC);
    assign lossCyc = cfg.rangeLo ? 8'(lkd_pkg::LOSS_LO_CYC)
                                 : 8'(lkd_pkg::LOSS_HI_CYC);
    assign target  = lock_target(cfg.cntLen);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree

    logic [2:0] refSync;
    logic [2:0] fbSync;
    logic       refLvl;
    logic       fbLvl;
    logic       refRise;
    logic       fbRise;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            refSync <= 3'b000;
            fbSync  <= 3'b000;
        end else begin
            refSync <= {refSync[1:0], phaseFreqDetectorRef};
            fbSync  <= {fbSync[1:0], phaseFreqDetectorFb};
        end
    end

    assign refRise = (refSync[1] == refSync[2]) && refSync[2] && !refLvl;
    assign fbRise  = (fbSync[1] == fbSync[2]) && fbSync[2] && !fbLvl;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            refLvl <= 1'b0;
            fbLvl  <= 1'b0;
        end else begin
            if (refSync[1] == refSync[2]) begin
                refLvl <= refSync[2];
            end
            if (fbSync[1] == fbSync[2]) begin
                fbLvl <= fbSync[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge separation measurement

    lkd_pkg::lkd_state_e state;
    lkd_pkg::lkd_state_e next_state;
    logic [7:0]          sepCnt;
    logic                measDone;
    logic [7:0]          measSep;
    logic                measIn;
    logic                measLost;

    always_comb begin
        next_state = state;
        measDone   = 1'b0;
        measSep    = sepCnt;
        unique case (state)
            lkd_pkg::ST_IDLE: begin
                if (refRise && fbRise) begin
                    measDone = 1'b1;
                    measSep  = 8'h00;
                end else if (refRise) begin
                    next_state = lkd_pkg::ST_WAIT_FB;
                end else if (fbRise) begin
                    next_state = lkd_pkg::ST_WAIT_REF;
                end
            end
            lkd_pkg::ST_WAIT_FB,
            lkd_pkg::ST_WAIT_REF: begin
                // a missing partner edge ends the cycle as a loss of lock
                if ((state == lkd_pkg::ST_WAIT_FB ? fbRise : refRise)
                    || sepCnt > lossCyc) begin
                    measDone   = 1'b1;
                    next_state = lkd_pkg::ST_IDLE;
                end
            end
        endcase
        if (cfg.detectOff) begin
            next_state = lkd_pkg::ST_IDLE;
            measDone   = 1'b0;
        end
    end

    assign measIn   = measSep <= winCyc;
    assign measLost = measSep > lossCyc;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= lkd_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sepCnt <= 8'h01;
        end else if (state == lkd_pkg::ST_IDLE) begin
            sepCnt <= 8'h01;
        end else if (sepCnt != 8'hFF) begin
            sepCnt <= sepCnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock counter and flag

    logic [7:0] lockCnt;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lockFlagDigital <= 1'b0;
            lockCnt         <= 8'h00;
        end else if (cfg.detectOff) begin
            lockFlagDigital <= 1'b0;
            lockCnt         <= 8'h00;
        end else if (measDone && !lockFlagDigital) begin
            if (!measIn) begin
                lockCnt <= 8'h00;
            end else if (lockCnt + 8'h01 >= target) begin
                lockFlagDigital <= 1'b1;
                lockCnt         <= 8'h00;
            end else begin
                lockCnt <= lockCnt + 8'h01;
            end
        end else if (measDone && measLost) begin
            // hysteresis: only a separation past the loss threshold unlocks
            lockFlagDigital <= 1'b0;
            lockCnt         <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    chk_flag_needs_window: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(lockFlagDigital) |-> $past(measDone && measIn))
        else $error("lock flag set without in-window cycle");

    chk_flag_holds: assert property (
        @(posedge mclk) disable iff (!rst_n)
        lockFlagDigital && !cfg.detectOff && !(measDone && measLost)
        |=> lockFlagDigital)
        else $error("lock flag dropped without loss of lock");

    chk_flag_drops: assert property (
        @(posedge mclk) disable iff (!rst_n)
        lockFlagDigital && measDone && measLost |=> !lockFlagDigital)
        else $error("lock flag kept after loss of lock");

    chk_timeout_ends: assert property (
        @(posedge mclk) disable iff (!rst_n)
        state != lkd_pkg::ST_IDLE && sepCnt > lossCyc && !cfg.detectOff
        |-> measDone && measLost ##1 state == lkd_pkg::ST_IDLE)
        else $error("missing edge not treated as loss");

    chk_len_16: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(lockFlagDigital) && $past(cfg.cntLen) == 2'b01
        |-> $past(lockCnt) == 8'h0f)
        else $error("lock after wrong count for code 01");

    chk_len_255: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(lockFlagDigital) && $past(cfg.cntLen) == 2'b11
        |-> $past(lockCnt) == 8'hfe)
        else $error("lock after wrong count for code 11");

    chk_window_high: assert property (
        @(posedge mclk) disable iff (!rst_n)
        measDone && !cfg.rangeLo && measSep > 8'h01 |-> !measIn)
        else $error("high range window wider than 3.5 ns");

    chk_detect_off: assert property (
        @(posedge mclk) disable iff (!rst_n)
        cfg.detectOff |=> !lockFlagDigital && lockCnt == 8'h00
                          && state == lkd_pkg::ST_IDLE)
        else $error("detector active while disabled");

    chk_count_restart: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !lockFlagDigital && measDone && !measIn && !cfg.detectOff
        |=> lockCnt == 8'h00 && !lockFlagDigital)
        else $error("count not restarted after out-of-window cycle");

    cov_lock: cover property (@(posedge mclk) disable iff (!rst_n)
        $rose(lockFlagDigital));
    cov_unlock: cover property (@(posedge mclk) disable iff (!rst_n)
        $fell(lockFlagDigital) && !cfg.detectOff);
    cov_restart: cover property (@(posedge mclk) disable iff (!rst_n)
        measDone && !measIn && lockCnt != 8'h00);
    cov_disable: cover property (@(posedge mclk) disable iff (!rst_n)
        lockFlagDigital ##1 cfg.detectOff);

endmodule

// ===== test_lkd_digital_lock_detect.sv
/*
 * test_lkd_digital_lock_detect: self-checking bench for the lock detector.
 * assumes the design package is compiled first; inputs change on falling
 * mclk edges and outputs are judged there, well clear of the rising edge.
 */
`timescale 1ns/1ps

module test_lkd_digital_lock_detect;

    logic       mclk;
    logic       rst_n;
    logic       phaseFreqDetectorRef;
    logic       phaseFreqDetectorFb;
    logic [7:0] regAddr;
    logic       regWrEn;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic       lockFlagDigital;
    int         failCount;
    int         checked;
    int         cycles;

    ////////////////////////////////////////////////////////////////////////

    lkd_digital_lock_detect lkd_digital_lock_detect_inst (
        .mclk                 (mclk),
        .rst_n                (rst_n),
        .phaseFreqDetectorRef (phaseFreqDetectorRef),
        .phaseFreqDetectorFb  (phaseFreqDetectorFb),
        .regAddr              (regAddr),
        .regWrEn              (regWrEn),
        .regWrData            (regWrData),
        .regRdData            (regRdData),
        .lockFlagDigital      (lockFlagDigital)
    );

    always #4 mclk = ~mclk;

    // ceiling well above the roughly 4900 cycles the tests need
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            failCount++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic checkByte(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic checkFlag(input logic exp);
        checked++;
        if (lockFlagDigital !== exp) begin
            failCount++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp,
                     lockFlagDigital);
        end
    endtask

    task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
        @(negedge mclk);
        regAddr = addr;
        regWrData = data;
        regWrEn = 1'b1;
        @(negedge mclk);
        regWrEn = 1'b0;
    endtask

    // read data is registered, so two edges keep clear of the write edge
    task automatic regRead(input logic [7:0] addr, output logic [7:0] data);
        @(negedge mclk);
        regAddr = addr;
        repeat (2) @(negedge mclk);
        data = regRdData;
    endtask

    // sep is fb delay after ref in cycles; long low phase lets each land
    task automatic pulses(input int n, input int sep);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            phaseFreqDetectorRef = 1'b1;
            repeat (sep) @(negedge mclk);
            phaseFreqDetectorFb = 1'b1;
            repeat (4) @(negedge mclk);
            phaseFreqDetectorRef = 1'b0;
            phaseFreqDetectorFb = 1'b0;
            repeat (6) @(negedge mclk);
        end
    endtask

    // feedback leads: walks the wait-for-reference path of the measurement
    task automatic pulsesFbFirst(input int n, input int sep);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            phaseFreqDetectorFb = 1'b1;
            repeat (sep) @(negedge mclk);
            phaseFreqDetectorRef = 1'b1;
            repeat (4) @(negedge mclk);
            phaseFreqDetectorRef = 1'b0;
            phaseFreqDetectorFb = 1'b0;
            repeat (6) @(negedge mclk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////

    task automatic testRegisters();
        logic [7:0] rd;
        regRead(lkd_pkg::REG_PLL_PFD_PULSE_CONFIG, rd);
        checkByte(lkd_pkg::RST_PLL_PFD_PULSE_CONFIG, rd);
        regRead(lkd_pkg::REG_LOCK_DETECT_CONFIG, rd);
        checkByte(lkd_pkg::RST_LOCK_DETECT_CONFIG, rd);
        regWrite(8'h17, 8'hA5);
        regWrite(8'h18, 8'h81);
        regWrite(8'h19, 8'h5A);
        regRead(8'h17, rd);
        checkByte(8'hA5, rd);
        regRead(8'h18, rd);
        checkByte(8'h81, rd);
        regRead(8'h19, rd);
        checkByte(8'h00, rd);
        $display("test registers done");
    endtask

    // each code: one short of target stays clear, target sets, disable clears
    task automatic testCounterCodes();
        logic [7:0] target [4];
        target = '{lkd_pkg::LOCK_CNT_00, lkd_pkg::LOCK_CNT_01,
                   lkd_pkg::LOCK_CNT_10, lkd_pkg::LOCK_CNT_11};
        for (int c = 0; c < 4; c++) begin
            regWrite(8'h18, {1'b0, 2'(c), 5'h00});
            pulses(int'(target[c]) - 1, 0);
            checkFlag(1'b0);
            pulses(1, 0);
            checkFlag(1'b1);
            regWrite(8'h18, {1'b0, 2'(c), 5'h08});
            repeat (2) @(negedge mclk);
            checkFlag(1'b0);
            pulses(2, 0);
            checkFlag(1'b0);
        end
        $display("test counter codes done");
    endtask

    task automatic testRestartAndHold();
        regWrite(8'h18, 8'h20);
        pulses(10, 0);
        pulses(1, 2);
        pulses(15, 0);
        checkFlag(1'b0);
        pulses(1, 0);
        checkFlag(1'b1);
        pulses(3, 2);
        checkFlag(1'b1);
        pulses(1, 4);
        checkFlag(1'b0);
        $display("test restart and hold done");
    endtask

    // two-cycle gaps miss the high window but fit the low one
    task automatic testRange();
        regWrite(8'h18, 8'h30);
        pulses(16, 2);
        checkFlag(1'b1);
        regWrite(8'h18, 8'h20);
        pulses(1, 4);
        pulses(16, 2);
        checkFlag(1'b0);
        $display("test range done");
    endtask

    // feedback-first lock, then a lone reference edge must time out as loss
    task automatic testMissingEdge();
        regWrite(8'h18, 8'h20);
        pulsesFbFirst(16, 1);
        checkFlag(1'b1);
        pulsesFbFirst(1, 3);
        checkFlag(1'b1);
        @(negedge mclk);
        phaseFreqDetectorRef = 1'b1;
        repeat (4) @(negedge mclk);
        phaseFreqDetectorRef = 1'b0;
        repeat (10) @(negedge mclk);
        checkFlag(1'b0);
        $display("test missing edge done");
    endtask

    ////////////////////////////////////////////////////////////////////////

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        phaseFreqDetectorRef = 1'b0;
        phaseFreqDetectorFb = 1'b0;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        failCount = 0;
        checked = 0;
        cycles = 0;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        checkFlag(1'b0);
        testRegisters();
        testCounterCodes();
        testRestartAndHold();
        testRange();
        testMissingEdge();
        report_and_stop();
    end

endmodule
